// file: hdl/usbpc_pkg.sv
// constants for the usb phy control register block
package usbpc_pkg;
   // ------------------------------------------------------------------
   // register map
   // ------------------------------------------------------------------
   localparam logic [7:0] ADDR_PHY_CONTROL = 8'h40;
   localparam logic [7:0] ADDR_IRQ_STATUS  = 8'h44;
   localparam logic [7:0] ADDR_IRQ_MASK    = 8'h48;
   localparam logic [7:0] ADDR_LINE_STATUS = 8'h4c;
   // ------------------------------------------------------------------
   // control field positions
   // ------------------------------------------------------------------
   localparam int PULLDOWN_DIS_BIT = 18;
   localparam int RESET_CAUSE_BIT  = 13;
   localparam int RESUME_CAUSE_BIT = 12;
   localparam int FILT_LSB         = 8;
   localparam int FILT_W           = 4;
   localparam int HW_RESUME_BIT    = 7;
   localparam int CFG_LSB          = 4;
   localparam int CFG_W            = 3;
   localparam logic [31:0] CTRL_WMASK  = 32'h0004_3ff0;
   localparam logic [31:0] CTRL_RESET  = 32'h0000_0000;
   // ------------------------------------------------------------------
   // line state codes and irq bits
   // ------------------------------------------------------------------
   localparam logic [1:0] LS_SE0 = 2'h0;
   localparam logic [1:0] LS_J   = 2'h1;
   localparam logic [1:0] LS_K   = 2'h2;
   localparam int IRQ_W          = 3;
   localparam int IRQ_RESET_BIT  = 0;
   localparam int IRQ_RESUME_BIT = 1;
   localparam int IRQ_LINE_BIT   = 2;
   localparam int CNT_W          = 16;
endpackage : usbpc_pkg

// file: hdl/usbpc_line_filter.sv
// line state change filter with power-of-two settle count
module usbpc_line_filter (
   input  wire logic       ref_clk_i,
   input  wire logic       resetn_i,
   input  wire logic [3:0] log2_cnt_i,
   input  wire logic [1:0] line_raw_i,
   output logic      [1:0] line_filt_o,
   output logic            change_o
);
   logic [1:0]                     cand_r;
   logic [1:0]                     filt_r;
   logic                           chg_r;
   logic [usbpc_pkg::CNT_W-1:0]    cnt_r;
   logic [usbpc_pkg::CNT_W-1:0]    cnt_nxt;
   logic [usbpc_pkg::CNT_W-1:0]    target;
   wire                            raw_moved = line_raw_i != cand_r;
   wire                            settled;

   assign target  = usbpc_pkg::CNT_W'(1) << log2_cnt_i;
   // restart on each raw change, so glitches never pass
   // saturate at or above target: a count lowered mid-settle still ends
   assign cnt_nxt = raw_moved ? usbpc_pkg::CNT_W'(1) :
                    (cnt_r >= target ? cnt_r : cnt_r + 1'b1);
   assign settled = !raw_moved && cnt_r >= target && cand_r != filt_r;

   always_ff @(posedge ref_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         cand_r <= usbpc_pkg::LS_J;
         filt_r <= usbpc_pkg::LS_J;
         cnt_r  <= '0;
         chg_r  <= 1'b0;
      end else begin
         cand_r <= line_raw_i;
         cnt_r  <= cnt_nxt;
         chg_r  <= settled;
         if (settled) begin
            filt_r <= cand_r;
         end
      end
   end

   assign line_filt_o = filt_r;
   assign change_o    = chg_r;

   stable_before_a: assert property (@(posedge ref_clk_i)
      disable iff (!resetn_i)
      settled |-> $stable(line_raw_i) && cnt_r >= target)
      else $error("filter output moved on unsettled line");
endmodule : usbpc_line_filter

// file: hdl/usbpc_phy_ctrl.sv
// usb phy control register with line filter and auto-resume cause flags
// ----------------------------------------------------------------------
// ports and state
// ----------------------------------------------------------------------
module usbpc_phy_ctrl (
   input  wire logic        ref_clk_i,
   input  wire logic        resetn_i,
   input  wire logic [7:0]  addr_i,
   input  wire logic [31:0] wdata_i,
   input  wire logic        wr_i,
   input  wire logic        rd_i,
   output logic      [31:0] rdata_o,
   input  wire logic [1:0]  line_raw_i,
   input  wire logic        suspended_i,
   output logic             resume_o,
   output logic             pulldown_a_en_o,
   output logic             pulldown_b_en_o,
   output logic      [2:0]  phy_config_pins_o,
   output logic             irq_o
);
   logic [31:0]                 ctrl_r;
   logic [31:0]                 ctrl_nxt;
   logic [31:0]                 rdata_r;
   logic [usbpc_pkg::IRQ_W-1:0] sts_r;
   logic [usbpc_pkg::IRQ_W-1:0] sts_nxt;
   logic [usbpc_pkg::IRQ_W-1:0] mask_r;
   logic                        irq_r;
   logic                        resume_r;
   logic                        pd_a_r;
   logic                        pd_b_r;
   logic [2:0]                  cfg_r;
   logic [1:0]                  line_filt;
   logic                        line_chg;

   // ----------------------------------------------------------------------
   // decode
   // ----------------------------------------------------------------------
   wire sel_ctrl = addr_i == usbpc_pkg::ADDR_PHY_CONTROL;
   wire sel_sts  = addr_i == usbpc_pkg::ADDR_IRQ_STATUS;
   wire sel_mask = addr_i == usbpc_pkg::ADDR_IRQ_MASK;
   wire sel_line = addr_i == usbpc_pkg::ADDR_LINE_STATUS;
   wire wr_ctrl  = wr_i && sel_ctrl;
   // irq looks at the mask being written, so it never lags a mask change
   wire [usbpc_pkg::IRQ_W-1:0] mask_nxt =
      (wr_i && sel_mask) ? wdata_i[usbpc_pkg::IRQ_W-1:0] : mask_r;
   wire hw_res   = ctrl_r[usbpc_pkg::HW_RESUME_BIT];
   // auto-resume only in hardware-resume mode while suspended
   wire auto_se0 = hw_res && suspended_i && line_chg &&
                   line_filt == usbpc_pkg::LS_SE0;
   wire auto_k   = hw_res && suspended_i && line_chg &&
                   line_filt == usbpc_pkg::LS_K;
   wire [usbpc_pkg::IRQ_W-1:0] ev = {line_chg, auto_k, auto_se0};

   usbpc_line_filter u_filt (
      .ref_clk_i  (ref_clk_i),
      .resetn_i   (resetn_i),
      .log2_cnt_i (ctrl_r[usbpc_pkg::FILT_LSB +: usbpc_pkg::FILT_W]),
      .line_raw_i (line_raw_i),
      .line_filt_o(line_filt),
      .change_o   (line_chg)
   );

   // ----------------------------------------------------------------------
   // next values
   // ----------------------------------------------------------------------
   always_comb begin
      ctrl_nxt = ctrl_r;
      if (wr_ctrl) begin
         ctrl_nxt = wdata_i & usbpc_pkg::CTRL_WMASK;
         // cause flags only clear by writing 0; a 1 keeps them
         ctrl_nxt[usbpc_pkg::RESET_CAUSE_BIT] =
            ctrl_r[usbpc_pkg::RESET_CAUSE_BIT] &
            wdata_i[usbpc_pkg::RESET_CAUSE_BIT];
         ctrl_nxt[usbpc_pkg::RESUME_CAUSE_BIT] =
            ctrl_r[usbpc_pkg::RESUME_CAUSE_BIT] &
            wdata_i[usbpc_pkg::RESUME_CAUSE_BIT];
      end
      // set wins over a clearing write
      if (auto_se0) begin
         ctrl_nxt[usbpc_pkg::RESET_CAUSE_BIT] = 1'b1;
      end
      if (auto_k) begin
         ctrl_nxt[usbpc_pkg::RESUME_CAUSE_BIT] = 1'b1;
      end
   end

   assign sts_nxt = ((rd_i && sel_sts) ? '0 : sts_r) | ev;

   wire [31:0] rd_mux =
      sel_ctrl ? ctrl_r :
      sel_sts  ? 32'(sts_r) :
      sel_mask ? 32'(mask_r) :
      sel_line ? 32'(line_filt) : 32'h0000_0000;

   // ----------------------------------------------------------------------
   // registers
   // ----------------------------------------------------------------------
   always_ff @(posedge ref_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         ctrl_r   <= usbpc_pkg::CTRL_RESET;
         sts_r    <= '0;
         mask_r   <= '0;
         rdata_r  <= 32'h0000_0000;
         irq_r    <= 1'b0;
         resume_r <= 1'b0;
         pd_a_r   <= 1'b1;
         pd_b_r   <= 1'b1;
         cfg_r    <= 3'h0;
      end else begin
         ctrl_r   <= ctrl_nxt;
         sts_r    <= sts_nxt;
         mask_r   <= mask_nxt;
         rdata_r  <= rd_i ? rd_mux : 32'h0000_0000;
         irq_r    <= |(sts_nxt & mask_nxt);
         resume_r <= auto_se0 || auto_k;
         pd_a_r   <= !ctrl_nxt[usbpc_pkg::PULLDOWN_DIS_BIT];
         pd_b_r   <= !ctrl_nxt[usbpc_pkg::PULLDOWN_DIS_BIT];
         cfg_r    <= ctrl_nxt[usbpc_pkg::CFG_LSB +: usbpc_pkg::CFG_W];
      end
   end

   assign rdata_o           = rdata_r;
   assign irq_o             = irq_r;
   assign resume_o          = resume_r;
   assign pulldown_a_en_o   = pd_a_r;
   assign pulldown_b_en_o   = pd_b_r;
   assign phy_config_pins_o = cfg_r;

   // ----------------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------------
   // checker helper: cycles the raw line has held one value
   logic [1:0]                  raw_prev_r;
   logic [usbpc_pkg::CNT_W-1:0] hold_cnt_r;
   wire  [usbpc_pkg::CNT_W-1:0] settle_len = usbpc_pkg::CNT_W'(1) <<
      ctrl_r[usbpc_pkg::FILT_LSB +: usbpc_pkg::FILT_W];

   always_ff @(posedge ref_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         raw_prev_r <= usbpc_pkg::LS_J;
         hold_cnt_r <= '0;
      end else begin
         raw_prev_r <= line_raw_i;
         if (line_raw_i != raw_prev_r) begin
            hold_cnt_r <= '0;
         end else if (hold_cnt_r != '1) begin
            hold_cnt_r <= hold_cnt_r + 1'b1;
         end
      end
   end

   pulldown_follow_a: assert property (@(posedge ref_clk_i)
      disable iff (!resetn_i)
      pulldown_a_en_o == !ctrl_r[usbpc_pkg::PULLDOWN_DIS_BIT] &&
      pulldown_b_en_o == pulldown_a_en_o)
      else $error("pulldown enable disagrees with control bit");
   reset_cause_a: assert property (@(posedge ref_clk_i)
      disable iff (!resetn_i)
      auto_se0 |=> ctrl_r[usbpc_pkg::RESET_CAUSE_BIT])
      else $error("reset cause not set");
   reset_hold_a: assert property (@(posedge ref_clk_i)
      disable iff (!resetn_i)
      ctrl_r[usbpc_pkg::RESET_CAUSE_BIT] && !wr_ctrl
      |=> ctrl_r[usbpc_pkg::RESET_CAUSE_BIT])
      else $error("reset cause dropped without write");
   resume_cause_a: assert property (@(posedge ref_clk_i)
      disable iff (!resetn_i)
      auto_k |=> ctrl_r[usbpc_pkg::RESUME_CAUSE_BIT])
      else $error("resume cause not set");
   resume_hold_a: assert property (@(posedge ref_clk_i)
      disable iff (!resetn_i)
      ctrl_r[usbpc_pkg::RESUME_CAUSE_BIT] && !wr_ctrl
      |=> ctrl_r[usbpc_pkg::RESUME_CAUSE_BIT])
      else $error("resume cause dropped without write");
   filter_delay_a: assert property (@(posedge ref_clk_i)
      disable iff (!resetn_i)
      $changed(line_filt) && ctrl_r[11:8] == 4'h0
      |-> $past(line_raw_i, 2) == line_filt)
      else $error("filtered line moved without settling");
   hw_resume_a: assert property (@(posedge ref_clk_i)
      disable iff (!resetn_i)
      resume_o |-> $past(hw_res) && $past(suspended_i))
      else $error("resume pulse without hardware resume mode");
   config_pins_a: assert property (@(posedge ref_clk_i)
      disable iff (!resetn_i)
      phy_config_pins_o == ctrl_r[6:4])
      else $error("config pins differ from field");
   irq_level_a: assert property (@(posedge ref_clk_i)
      disable iff (!resetn_i)
      irq_o == |(sts_r & mask_r))
      else $error("interrupt out of step with status");
   read_data_a: assert property (@(posedge ref_clk_i)
      disable iff (!resetn_i)
      rd_i && sel_ctrl |=> rdata_o == $past(ctrl_r))
      else $error("control read data wrong");
   settle_len_a: assert property (@(posedge ref_clk_i)
      disable iff (!resetn_i)
      $changed(line_filt) |-> hold_cnt_r >= $past(settle_len))
      else $error("filtered line moved before the settle count");
   reset_clear_a: assert property (@(posedge ref_clk_i)
      disable iff (!resetn_i)
      wr_ctrl && !wdata_i[usbpc_pkg::RESET_CAUSE_BIT] && !auto_se0
      |=> !ctrl_r[usbpc_pkg::RESET_CAUSE_BIT])
      else $error("reset cause not cleared by zero write");
   resume_clear_a: assert property (@(posedge ref_clk_i)
      disable iff (!resetn_i)
      wr_ctrl && !wdata_i[usbpc_pkg::RESUME_CAUSE_BIT] && !auto_k
      |=> !ctrl_r[usbpc_pkg::RESUME_CAUSE_BIT])
      else $error("resume cause not cleared by zero write");
   resume_pulse_a: assert property (@(posedge ref_clk_i)
      disable iff (!resetn_i)
      resume_o |=> !resume_o)
      else $error("resume pulse longer than one cycle");
   status_set_a: assert property (@(posedge ref_clk_i)
      disable iff (!resetn_i)
      |ev |=> (sts_r & $past(ev)) == $past(ev))
      else $error("status bit not set by event");
   status_clear_a: assert property (@(posedge ref_clk_i)
      disable iff (!resetn_i)
      rd_i && sel_sts && ev == '0 |=> sts_r == '0)
      else $error("status not cleared by read");
   rdata_idle_a: assert property (@(posedge ref_clk_i)
      disable iff (!resetn_i)
      !rd_i |=> rdata_o == 32'h0000_0000)
      else $error("read data not zero outside a read");

   se0_resume_c: cover property (@(posedge ref_clk_i)
      disable iff (!resetn_i) auto_se0);
   k_resume_c: cover property (@(posedge ref_clk_i)
      disable iff (!resetn_i) auto_k);
   clear_race_c: cover property (@(posedge ref_clk_i)
      disable iff (!resetn_i) auto_k && wr_ctrl);
   irq_c: cover property (@(posedge ref_clk_i)
      disable iff (!resetn_i) irq_o);
   polled_change_c: cover property (@(posedge ref_clk_i)
      disable iff (!resetn_i) line_chg && !hw_res && suspended_i);
endmodule : usbpc_phy_ctrl

// file: bench/usbpc_bus_model.sv
// bus side model: drives the raw line state and the suspend level
module usbpc_bus_model (
   input  wire logic       ref_clk_i,
   input  wire logic       resetn_i,
   input  wire logic [1:0] line_req_i,
   input  wire logic       susp_req_i,
   output logic      [1:0] line_o,
   output logic            susp_o
);
   timeunit 1ns;
   timeprecision 1ns;
   // idle bus shows j; levels move only after an edge, like a real phy
   always_ff @(posedge ref_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         line_o <= 2'h1;
         susp_o <= 1'h0;
      end else begin
         line_o <= line_req_i;
         susp_o <= susp_req_i;
      end
   end
endmodule : usbpc_bus_model

// file: bench/tb_top.sv
// self-checking bench for the usb phy control register
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin \
   miscompares++; $display("BAD t=%0t got=%h exp=%h", $time, a, b); \
   end end
module tb_top;
   timeunit 1ns;
   timeprecision 1ns;
   localparam logic [7:0] a_ctl = usbpc_pkg::ADDR_PHY_CONTROL;
   localparam logic [7:0] a_sts = usbpc_pkg::ADDR_IRQ_STATUS;
   localparam logic [7:0] a_msk = usbpc_pkg::ADDR_IRQ_MASK;
   localparam logic [7:0] a_lin = usbpc_pkg::ADDR_LINE_STATUS;
   logic        ref_clk_i = 1'b0;
   logic        resetn_i  = 1'b0;
   logic [7:0]  addr_i    = 8'h00;
   logic [31:0] wdata_i   = 32'h0;
   logic        wr_i      = 1'b0;
   logic        rd_i      = 1'b0;
   logic [1:0]  line_req  = 2'h1;
   logic        susp_req  = 1'b0;
   logic [31:0] rd_v;
   logic [31:0] rdata_o;
   logic [1:0]  line_raw;
   logic [2:0]  cfg_o;
   logic        suspended, resume_o, pd_a, pd_b, irq_o;
   int          miscompares = 0;
   int          n_checks    = 0;
   int          n_res       = 0;
   always #25 ref_clk_i = ~ref_clk_i;
   always @(posedge ref_clk_i) if (resume_o === 1'b1) n_res++;
   usbpc_bus_model bus_u (.ref_clk_i(ref_clk_i), .resetn_i(resetn_i),
      .line_req_i(line_req), .susp_req_i(susp_req), .line_o(line_raw),
      .susp_o(suspended));
   usbpc_phy_ctrl dut_u (.ref_clk_i(ref_clk_i), .resetn_i(resetn_i),
      .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
      .rdata_o(rdata_o), .line_raw_i(line_raw), .suspended_i(suspended),
      .resume_o(resume_o), .pulldown_a_en_o(pd_a),
      .pulldown_b_en_o(pd_b), .phy_config_pins_o(cfg_o), .irq_o(irq_o));
   // ------------------------------------------------------------------
   // bus tasks
   // ------------------------------------------------------------------
   task automatic cyc(input int n);
      repeat (n) @(posedge ref_clk_i);
   endtask : cyc
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge ref_clk_i);
      addr_i  <= a;
      wdata_i <= d;
      wr_i    <= 1'b1;
      @(posedge ref_clk_i);
      wr_i <= 1'b0;
   endtask : wr
   // read data stand only in the cycle after the strobe
   task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
      @(posedge ref_clk_i);
      addr_i <= a;
      rd_i   <= 1'b1;
      @(posedge ref_clk_i);
      rd_i <= 1'b0;
      #1 rd_v = rdata_o;
      `CHK(rd_v, e)
   endtask : rdchk
   task automatic final_report;
      if (miscompares == 0 && n_checks > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask : final_report
   // ------------------------------------------------------------------
   // scenarios
   // ------------------------------------------------------------------
   task automatic t_reset;
      #1 `CHK({pd_a, pd_b, cfg_o, irq_o}, 6'h30)
      rdchk(a_ctl, 32'h0);
      rdchk(a_lin, 32'h1);
   endtask : t_reset
   task automatic t_ctrl;
      for (int i = 0; i < 8; i++) begin
         wr(a_ctl, (32'(i) << 4) | (i[0] ? 32'h0004_0000 : 32'h0000_0000));
         cyc(1);
         #1 `CHK({pd_a, pd_b, cfg_o}, {~i[0], ~i[0], i[2:0]})
      end
      wr(a_ctl, 32'hffff_ffff);
      rdchk(a_ctl, 32'h0004_0ff0);
      wr(8'h50, 32'h0);
      wr(a_lin, 32'h3);
      rdchk(8'h50, 32'h0);
      rdchk(a_ctl, 32'h0004_0ff0);
      rdchk(a_lin, 32'h1);
   endtask : t_ctrl
   task automatic t_filter;
      wr(a_ctl, 32'h200);
      line_req <= 2'h2;
      cyc(2);
      line_req <= 2'h1;
      cyc(12);
      rdchk(a_lin, 32'h1);
      line_req <= 2'h2;
      // four steady clocks: j read at the last edge before, k just after
      cyc(3);
      rdchk(a_lin, 32'h1);
      rdchk(a_lin, 32'h2);
      line_req <= 2'h1;
      cyc(10);
      rdchk(a_sts, 32'h4);
   endtask : t_filter
   task automatic t_auto;
      wr(a_msk, 32'hffff_fffa);
      rdchk(a_msk, 32'h2);
      wr(a_ctl, 32'h80);
      susp_req <= 1'b1;
      line_req <= 2'h2;
      cyc(8);
      `CHK(n_res, 1)
      #1 `CHK(irq_o, 1'b1)
      rdchk(a_ctl, 32'h1080);
      rdchk(a_sts, 32'h6);
      cyc(1);
      #1 `CHK(irq_o, 1'b0)
      wr(a_ctl, 32'h80);
      rdchk(a_ctl, 32'h80);
      line_req <= 2'h0;
      cyc(8);
      rdchk(a_ctl, 32'h2080);
      `CHK(irq_o, 1'b0)
      wr(a_ctl, 32'h2080);
      rdchk(a_ctl, 32'h2080);
      `CHK(n_res, 2)
      wr(a_ctl, 32'h0);
      line_req <= 2'h2;
      cyc(8);
      `CHK(n_res, 2)
      rdchk(a_ctl, 32'h0);
      rdchk(a_lin, 32'h2);
      wr(a_msk, 32'h1);
      #1 `CHK(irq_o, 1'b1)
      rdchk(a_sts, 32'h5);
      `CHK(irq_o, 1'b0)
   endtask : t_auto
   initial begin
      cyc(16);
      resetn_i <= 1'b1;
      t_reset();
      t_ctrl();
      t_filter();
      t_auto();
      final_report();
   end
   initial begin
      cyc(3000);
      miscompares++;
      final_report();
   end
endmodule : tb_top
